// file: logic_cell_params.svh
// constants for the logic cell storage and lut memory block
`ifndef LOGIC_CELL_PARAMS_SVH
`define LOGIC_CELL_PARAMS_SVH
`define LUT_ADDR_W 4
`define LUT_DEPTH 16
`define H_TRUTH_W 8
`define CLK_PERIOD_PS 5000
`define CTRL_SEL_W 2
`define DSEL_F 2'h0
`define DSEL_G 2'h1
`define DSEL_H 2'h2
`define DSEL_DIRECT 2'h3
`endif

// file: logic_cell_pkg.sv
// types for the logic cell storage and lut memory block
package logic_cell_pkg;
    typedef enum logic [3:0]
    {
        ORG_LOGIC = 4'b0001,
        ORG_16X2 = 4'b0010,
        ORG_32X1 = 4'b0100,
        ORG_DUAL = 4'b1000
    } ram_org_t;
    typedef enum logic [1:0]
    {
        WR_IDLE = 2'b01,
        WR_PULSE = 2'b10
    } wr_state_t;
endpackage

// file: logic_cell.sv
// logic cell: two storage elements and lut based memory
//
// Function
// - one bit picks set or reset everywhere
// - per element choice and local disable
// - local preset/clear active high, no inversion
// - global net forces configured state always
// - set elements set, reset elements cleared
// - global source pin or node, optional invert
// - element data from f, g, h, direct
// - output mux: element or any control input
// - any external control drives any internal
// - memory controls; d1 is fifth address
// - luts form 16x2, 32x1 or 16x1
// - two 16x1 with own data, addresses
// - one lut memory, others stay logic
// - sync write only on selected edge
// - one write timing mode for both luts
// - dual port: one write, two reads
// - single port shares read/write address
// - reads combinational and same in all modes
// - edge captures, then internal write pulse
// - write clock invertible apart from elements
// - second port gives second lut read address
// - shared active high gate, unconnected means on
`timescale 1ns/1ps
`include "logic_cell_params.svh"

module logic_cell
    import logic_cell_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // cell clock sampled on clk, and configuration load pulse
    input wire logic cell_clk,
    input wire logic cfg_load,
    // control routing
    input wire logic [3:0] external_control_inputs,
    input wire logic [1:0] sel_h1,
    input wire logic [1:0] sel_direct,
    input wire logic [1:0] sel_preset,
    input wire logic [1:0] sel_gate,
    // global preset/clear source
    input wire logic global_pin_in,
    input wire logic global_node_in,
    input wire logic global_from_pin,
    input wire logic global_invert,
    // storage element configuration, index 0 first, 1 second
    input wire logic [1:0] init_set,
    input wire logic [1:0] preset_enable,
    input wire logic [1:0] gate_connected,
    input wire logic [1:0] elem_clk_invert,
    input wire logic [1:0] dsel_first,
    input wire logic [1:0] dsel_second,
    input wire logic [1:0] bypass_en,
    input wire logic [1:0] bypass_sel_first,
    input wire logic [1:0] bypass_sel_second,
    // lut configuration
    input wire logic [15:0] f_truth,
    input wire logic [15:0] g_truth,
    input wire logic [7:0] h_truth,
    input wire logic h0_from_f,
    input wire logic h2_from_g,
    input wire logic x_from_h,
    input wire logic y_from_h,
    // memory configuration
    input wire ram_org_t ram_org,
    input wire logic [1:0] lut_ram_en,
    input wire logic write_async,
    input wire logic write_clk_invert,
    // lut addresses
    input wire logic [3:0] f_addr,
    input wire logic [3:0] g_addr,
    input wire logic [3:0] secondary_read_address,
    // outputs
    output logic lut_x_out,
    output logic lut_y_out,
    output logic primary_read_output,
    output logic secondary_read_output,
    output logic first_registered_output,
    output logic second_registered_output
);

    localparam int AW = `LUT_ADDR_W;
    localparam int DEPTH = `LUT_DEPTH;

    function automatic logic pick4(input logic [3:0] v,
                                   input logic [1:0] s);
        pick4 = v[s];
    endfunction

    function automatic logic lut_rd(input logic [DEPTH-1:0] m,
                                    input logic [AW-1:0] a);
        lut_rd = m[a];
    endfunction

    logic third_lut_input_one;
    logic direct_or_third_lut_input_two;
    logic preset_or_third_lut_input_zero;
    logic storage_clock_gate;
    logic memory_data_in_zero;
    logic memory_data_in_one;
    logic write_strobe;
    logic local_async_preset_clear;
    logic global_preset_clear_net;
    logic cclk_reg;
    logic clk_rise;
    logic clk_fall;
    logic wclk_edge;
    logic sync_mode;
    logic [1:0] elem_edge;
    logic [1:0] gate_ok;
    logic [1:0] force_elem;
    logic [1:0] q_reg;
    logic [1:0] q_out;
    logic [1:0] d_sel;
    logic [DEPTH-1:0] f_mem;
    logic [DEPTH-1:0] g_mem;
    logic f_rd;
    logic g_rd;
    logic [AW-1:0] g_rd_addr;
    logic f_prime;
    logic g_prime;
    logic h_prime;
    logic h_in0;
    logic h_in2;
    logic live_f_we;
    logic live_g_we;
    logic [AW-1:0] live_fa;
    logic [AW-1:0] live_ga;
    logic live_fd;
    logic live_gd;
    wr_state_t wr_state;
    logic cap_f_we;
    logic cap_g_we;
    logic [AW-1:0] cap_fa;
    logic [AW-1:0] cap_ga;
    logic cap_fd;
    logic cap_gd;

    always_comb
    begin
        third_lut_input_one = pick4(external_control_inputs, sel_h1);
        direct_or_third_lut_input_two =
            pick4(external_control_inputs, sel_direct);
        preset_or_third_lut_input_zero =
            pick4(external_control_inputs, sel_preset);
        storage_clock_gate = pick4(external_control_inputs, sel_gate);
    end

    // memory meaning of the internal controls
    assign write_strobe = preset_or_third_lut_input_zero;
    assign memory_data_in_zero = direct_or_third_lut_input_two;
    assign memory_data_in_one = third_lut_input_one;
    assign local_async_preset_clear = (ram_org == ORG_LOGIC) &&
        preset_or_third_lut_input_zero;

    assign global_preset_clear_net = global_invert ^
        (global_from_pin ? global_pin_in : global_node_in);

    // cell clock edges seen on clk
    always_ff @(posedge clk)
    begin
        if (!rstn)
            cclk_reg <= 1'b0;
        else
            cclk_reg <= cell_clk;
    end

    assign clk_rise = cell_clk && !cclk_reg;
    assign clk_fall = !cell_clk && cclk_reg;
    // write clock sense independent of elements
    assign wclk_edge = write_clk_invert ? clk_fall : clk_rise;
    // one timing mode; dual port always edge timed
    assign sync_mode = !write_async || (ram_org == ORG_DUAL);

    always_comb
    begin
        unique case (ram_org)
            // second port addresses second lut read
            ORG_DUAL: g_rd_addr = secondary_read_address;
            ORG_32X1: g_rd_addr = f_addr;
            default: g_rd_addr = g_addr;
        endcase
        f_rd = lut_rd(f_mem, f_addr);
        g_rd = lut_rd(g_mem, g_rd_addr);
        f_prime = f_rd;
        if (ram_org == ORG_32X1)
            f_prime = memory_data_in_one ? g_rd : f_rd;
        g_prime = g_rd;
    end

    // h stays a logic function beside memory
    assign h_in0 = h0_from_f ? f_prime : preset_or_third_lut_input_zero;
    assign h_in2 = h2_from_g ? g_prime : direct_or_third_lut_input_two;
    assign h_prime = h_truth[{h_in2, third_lut_input_one, h_in0}];
    assign lut_x_out = x_from_h ? h_prime : f_prime;
    assign lut_y_out = y_from_h ? h_prime : g_prime;
    assign primary_read_output = f_prime;
    assign secondary_read_output = g_rd;

    // write request decode per organisation
    always_comb
    begin
        live_f_we = 1'b0;
        live_g_we = 1'b0;
        live_fa = f_addr;
        live_ga = f_addr;
        live_fd = memory_data_in_zero;
        live_gd = memory_data_in_zero;
        unique case (ram_org)
            ORG_16X2:
            begin
                live_f_we = lut_ram_en[0];
                live_g_we = lut_ram_en[1];
                live_ga = g_addr;
                live_gd = memory_data_in_one;
            end
            ORG_32X1:
            begin
                live_f_we = !memory_data_in_one;
                live_g_we = memory_data_in_one;
            end
            ORG_DUAL:
            begin
                // one write port into both luts
                live_f_we = 1'b1;
                live_g_we = 1'b1;
            end
            ORG_LOGIC:
            begin
                live_f_we = 1'b0;
            end
            default:
            begin
                live_f_we = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            wr_state <= WR_IDLE;
        // write strobe acts only at the selected edge
        else if (sync_mode && wclk_edge && write_strobe &&
                 (live_f_we || live_g_we))
            wr_state <= WR_PULSE;
        else
            wr_state <= WR_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cap_f_we <= 1'b0;
            cap_g_we <= 1'b0;
            cap_fa <= '0;
            cap_ga <= '0;
            cap_fd <= 1'b0;
            cap_gd <= 1'b0;
        end
        else if (wclk_edge)
        begin
            cap_f_we <= live_f_we;
            cap_g_we <= live_g_we;
            cap_fa <= live_fa;
            cap_ga <= live_ga;
            cap_fd <= live_fd;
            cap_gd <= live_gd;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            f_mem <= '0;
            g_mem <= '0;
        end
        else if (cfg_load)
        begin
            f_mem <= f_truth;
            g_mem <= g_truth;
        end
        else if (sync_mode)
        begin
            if (wr_state == WR_PULSE && cap_f_we)
                f_mem[cap_fa] <= cap_fd;
            if (wr_state == WR_PULSE && cap_g_we)
                g_mem[cap_ga] <= cap_gd;
        end
        else if (write_strobe)
        begin
            if (live_f_we)
                f_mem[live_fa] <= live_fd;
            if (live_g_we)
                g_mem[live_ga] <= live_gd;
        end
    end

    // storage element controls
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            elem_edge[i] = elem_clk_invert[i] ? clk_fall : clk_rise;
            gate_ok[i] = !gate_connected[i] || storage_clock_gate;
            // per element disable of local input
            // both sources drive the same state
            force_elem[i] = global_preset_clear_net ||
                (preset_enable[i] && local_async_preset_clear);
        end
    end

    always_comb
    begin
        logic [3:0] src;
        src = {memory_data_in_zero, h_prime, g_prime, f_prime};
        d_sel[0] = pick4(src, dsel_first);
        d_sel[1] = pick4(src, dsel_second);
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (!rstn || cfg_load || force_elem[i])
                // one bit sets every forced state
                q_reg[i] <= init_set[i];
            else if (elem_edge[i] && gate_ok[i])
                q_reg[i] <= d_sel[i];
        end
    end

    // forced value shows at once and holds
    always_comb
    begin
        for (int i = 0; i < 2; i++)
            q_out[i] = force_elem[i] ? init_set[i] : q_reg[i];
    end

    assign first_registered_output = bypass_en[0] ?
        pick4(external_control_inputs, bypass_sel_first) : q_out[0];
    assign second_registered_output = bypass_en[1] ?
        pick4(external_control_inputs, bypass_sel_second) : q_out[1];

    sequence s_sync_capture;
        sync_mode && wclk_edge && write_strobe && live_f_we &&
            !cfg_load;
    endsequence

    sequence s_pulse_then_written(logic [AW-1:0] a, logic d);
        wr_state == WR_PULSE ##1 f_mem[a] == d;
    endsequence

    chk_sr_holds_init: assert property (
        @(posedge clk) disable iff (!rstn)
        force_elem[0] && !bypass_en[0] |->
            first_registered_output == init_set[0])
        else $error("forced element not at configured value");

    chk_global_forces_all: assert property (
        @(posedge clk) disable iff (!rstn)
        global_preset_clear_net |=> q_reg == $past(init_set))
        else $error("global net did not force both elements");

    // capture at t, pulse seen at t+1, cell written by t+2
    chk_sync_write_seq: assert property (
        @(posedge clk) disable iff (!rstn)
        s_sync_capture ##1 (sync_mode && !cfg_load) |->
            s_pulse_then_written($past(f_addr, 2), $past(live_fd, 2)))
        else $error("edge write not performed by the pulse");

    chk_no_write_off_edge: assert property (
        @(posedge clk) disable iff (!rstn)
        sync_mode && wr_state == WR_IDLE && !cfg_load |=>
            $stable(f_mem) && $stable(g_mem))
        else $error("memory changed without a write pulse");

    chk_async_level_write: assert property (
        @(posedge clk) disable iff (!rstn)
        !sync_mode && write_strobe && live_f_we && !cfg_load |=>
            f_mem[$past(live_fa)] == $past(live_fd))
        else $error("level write did not store data");

    chk_dual_second_read: assert property (
        @(posedge clk) disable iff (!rstn)
        ram_org == ORG_DUAL |->
            secondary_read_output == g_mem[secondary_read_address])
        else $error("second port read wrong address");

    chk_elem_load: assert property (
        @(posedge clk) disable iff (!rstn)
        elem_edge[0] && gate_ok[0] && !force_elem[0] && !cfg_load
            |=> q_reg[0] == $past(d_sel[0]))
        else $error("element did not load selected data");

    chk_gate_holds: assert property (
        @(posedge clk) disable iff (!rstn)
        !gate_ok[1] && !force_elem[1] && !cfg_load |=>
            $stable(q_reg[1]))
        else $error("element changed with gate low");

    chk_bypass_path: assert property (
        @(posedge clk) disable iff (!rstn)
        bypass_en[1] |-> second_registered_output ==
            external_control_inputs[bypass_sel_second])
        else $error("bypass did not pass control input");

endmodule // logic_cell

// file: user_fabric.sv
// surrounding user logic: cell clock pulses and a level write strobe
`timescale 1ns/1ps

module user_fabric
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pulse request
    input wire logic pulse_req,
    input wire logic with_edge,
    input wire logic with_strobe,
    // towards the cell
    output logic cell_clk,
    output logic strobe,
    output logic busy
);
    logic [2:0] cnt_reg;
    logic edge_reg;
    logic strobe_reg;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cnt_reg <= 3'h0;
            edge_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end
        else if (pulse_req && cnt_reg == 3'h0)
        begin
            cnt_reg <= 3'h5;
            edge_reg <= with_edge;
            strobe_reg <= with_strobe;
        end
        else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
    end

    // cell clock stands low between pulses, high for three cycles
    assign cell_clk = edge_reg && cnt_reg >= 3'h3;
    // strobe held as a level around both clock edges
    assign strobe = strobe_reg && cnt_reg != 3'h0;
    assign busy = cnt_reg != 3'h0;
endmodule // user_fabric

// file: logic_cell_tb.sv
// self-checking bench for the logic cell storage and lut memory
`timescale 1ns/1ps
`include "logic_cell_params.svh"

module logic_cell_tb
    import logic_cell_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cfg_load = 1'b0;
    logic [3:1] ctl = 3'h0;
    logic req = 1'b0;
    logic w_edge = 1'b0;
    logic w_strobe = 1'b0;
    logic cell_clk;
    logic strobe;
    logic busy;
    logic [3:0] external_control_inputs;
    logic [1:0] sel_h1 = 2'h2;
    logic [1:0] sel_direct = 2'h1;
    logic [1:0] sel_preset = 2'h0;
    logic [1:0] sel_gate = 2'h3;
    logic global_pin_in = 1'b1;
    logic global_node_in = 1'b0;
    logic global_from_pin = 1'b0;
    logic global_invert = 1'b0;
    logic [1:0] init_set = 2'h2;
    logic [1:0] preset_enable = 2'h0;
    logic [1:0] gate_connected = 2'h3;
    logic [1:0] elem_clk_invert = 2'h0;
    logic [1:0] dsel_first = `DSEL_DIRECT;
    logic [1:0] dsel_second = `DSEL_DIRECT;
    logic [1:0] bypass_en = 2'h0;
    logic [1:0] bypass_sel_first = 2'h1;
    logic [1:0] bypass_sel_second = 2'h3;
    logic [15:0] f_truth = 16'ha5c3;
    logic [15:0] g_truth = 16'h3c96;
    logic [15:0] fm = 16'ha5c3;
    logic [15:0] gm = 16'h3c96;
    logic [7:0] h_truth = 8'hf0;
    logic h0_from_f = 1'b0;
    logic h2_from_g = 1'b0;
    logic x_from_h = 1'b0;
    logic y_from_h = 1'b0;
    ram_org_t ram_org = ORG_LOGIC;
    logic [1:0] lut_ram_en = 2'h3;
    logic write_async = 1'b0;
    logic write_clk_invert = 1'b0;
    logic [3:0] f_addr = 4'h0;
    logic [3:0] g_addr = 4'h0;
    logic [3:0] secondary_read_address = 4'h0;
    logic lut_x_out;
    logic lut_y_out;
    logic primary_read_output;
    logic secondary_read_output;
    logic first_registered_output;
    logic second_registered_output;
    int n_errors = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;
    assign external_control_inputs = {ctl, strobe};

    user_fabric i_fabric (.clk, .rstn, .pulse_req(req), .with_edge(w_edge),
        .with_strobe(w_strobe), .cell_clk, .strobe, .busy);

    logic_cell i_dut (.clk, .rstn, .cell_clk, .cfg_load,
        .external_control_inputs, .sel_h1, .sel_direct, .sel_preset,
        .sel_gate, .global_pin_in, .global_node_in, .global_from_pin,
        .global_invert, .init_set, .preset_enable, .gate_connected,
        .elem_clk_invert, .dsel_first, .dsel_second, .bypass_en,
        .bypass_sel_first, .bypass_sel_second, .f_truth, .g_truth, .h_truth,
        .h0_from_f, .h2_from_g, .x_from_h, .y_from_h, .ram_org, .lut_ram_en,
        .write_async, .write_clk_invert, .f_addr, .g_addr,
        .secondary_read_address, .lut_x_out, .lut_y_out,
        .primary_read_output, .secondary_read_output,
        .first_registered_output, .second_registered_output);

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one partner pulse, waited for under a bound
    task automatic pulse(input logic e, input logic s);
        int i;
        w_edge = e;
        w_strobe = s;
        req = 1'b1;
        cyc(1);
        req = 1'b0;
        for (i = 0; i < 20 && busy; i++)
            cyc(1);
        if (busy)
        begin
            n_errors++;
            complete_run();
        end
        cyc(2);
    endtask

    task automatic qchk(input logic [1:0] q);
        chk("first q", first_registered_output, q[0]);
        chk("second q", second_registered_output, q[1]);
    endtask

    task automatic pq(input logic [3:1] c, input logic [1:0] gc,
        input logic [1:0] pe, input logic e, input logic s,
        input logic [1:0] q);
        ctl = c;
        gate_connected = gc;
        preset_enable = pe;
        pulse(e, s);
        qchk(q);
    endtask

    // data is always the inverse of the stored bit, so a write shows
    task automatic memw(input logic [3:0] fa, input logic [3:0] ga,
        input logic e, input logic s, input logic [1:0] we);
        f_addr = fa;
        g_addr = ga;
        ctl = {1'b0, ~gm[ga], ~fm[fa]};
        if (we[0])
            fm[fa] = ~fm[fa];
        if (we[1])
            gm[ga] = ~gm[ga];
        pulse(e, s);
        chk("f mem", lut_x_out, fm[fa]);
        chk("g mem", lut_y_out, gm[ga]);
    endtask

    initial
    begin
        cyc(8);
        qchk(2'b10);
        rstn = 1'b1;
        cfg_load = 1'b1;
        cyc(1);
        cfg_load = 1'b0;
        for (int a = 0; a < 16; a++)
        begin
            f_addr = 4'(a);
            g_addr = 4'(15 - a);
            cyc(1);
            chk("f read", lut_x_out, f_truth[a]);
            chk("g read", lut_y_out, g_truth[15 - a]);
        end
        pq(3'b100, 2'h3, 2'h0, 1'b1, 1'b0, 2'b00);
        pq(3'b001, 2'h3, 2'h0, 1'b1, 1'b0, 2'b00);
        pq(3'b001, 2'h2, 2'h0, 1'b1, 1'b0, 2'b01);
        global_node_in = 1'b1;
        cyc(1);
        qchk(2'b10);
        global_node_in = 1'b0;
        global_from_pin = 1'b1;
        global_pin_in = 1'b0;
        global_invert = 1'b1;
        cyc(1);
        qchk(2'b10);
        global_pin_in = 1'b1;
        pq(3'b100, 2'h3, 2'h0, 1'b1, 1'b0, 2'b00);
        pq(3'b001, 2'h2, 2'h0, 1'b1, 1'b0, 2'b01);
        pq(3'b000, 2'h3, 2'h1, 1'b0, 1'b1, 2'b00);
        pq(3'b000, 2'h3, 2'h3, 1'b0, 1'b1, 2'b10);
        pq(3'b101, 2'h3, 2'h3, 1'b1, 1'b1, 2'b10);
        bypass_en = 2'h3;
        ctl = 3'b001;
        cyc(1);
        qchk(2'b01);
        ctl = 3'b100;
        cyc(1);
        qchk(2'b10);
        bypass_en = 2'h0;
        x_from_h = 1'b1;
        y_from_h = 1'b1;
        sel_direct = 2'h3;
        cyc(1);
        chk("h x", lut_x_out, 1'b1);
        chk("h y", lut_y_out, 1'b1);
        sel_direct = 2'h1;
        cyc(1);
        chk("h x", lut_x_out, 1'b0);
        x_from_h = 1'b0;
        y_from_h = 1'b0;
        // first element on the falling edge, second on the rising
        elem_clk_invert = 2'h1;
        ctl = 3'b101;
        w_edge = 1'b1;
        w_strobe = 1'b0;
        req = 1'b1;
        cyc(1);
        req = 1'b0;
        cyc(2);
        qchk(2'b10);
        cyc(4);
        qchk(2'b11);
        elem_clk_invert = 2'h0;
        // f reads 1 at address f, g reads 0 at address 0, h gives 0
        h0_from_f = 1'b1;
        h2_from_g = 1'b1;
        dsel_first = `DSEL_H;
        dsel_second = `DSEL_G;
        pq(3'b101, 2'h3, 2'h0, 1'b1, 1'b0, 2'b00);
        dsel_first = `DSEL_F;
        pq(3'b100, 2'h3, 2'h0, 1'b1, 1'b0, 2'b01);
        ram_org = ORG_16X2;
        memw(4'h0, 4'hf, 1'b1, 1'b1, 2'h3);
        memw(4'h9, 4'h6, 1'b1, 1'b1, 2'h3);
        memw(4'h9, 4'h6, 1'b1, 1'b0, 2'h0);
        memw(4'h9, 4'h6, 1'b0, 1'b1, 2'h0);
        write_clk_invert = 1'b1;
        memw(4'hf, 4'h0, 1'b1, 1'b1, 2'h3);
        lut_ram_en = 2'h1;
        memw(4'h5, 4'h5, 1'b1, 1'b1, 2'h1);
        lut_ram_en = 2'h3;
        write_async = 1'b1;
        memw(4'h7, 4'h7, 1'b0, 1'b1, 2'h3);
        write_async = 1'b0;
        ram_org = ORG_32X1;
        f_addr = 4'h5;
        g_addr = 4'h5;
        ctl = {2'b01, ~gm[5]};
        gm[5] = ~gm[5];
        pulse(1'b1, 1'b1);
        chk("a4 high", primary_read_output, gm[5]);
        ctl[2] = 1'b0;
        cyc(1);
        chk("a4 low", primary_read_output, fm[5]);
        ram_org = ORG_DUAL;
        f_addr = 4'h3;
        secondary_read_address = 4'h3;
        ctl = {2'b00, ~fm[3]};
        fm[3] = ~fm[3];
        pulse(1'b1, 1'b1);
        chk("dual a", primary_read_output, fm[3]);
        chk("dual b", secondary_read_output, fm[3]);
        secondary_read_address = 4'h4;
        cyc(1);
        chk("dual c", secondary_read_output, gm[4]);
        complete_run();
    end
endmodule // logic_cell_tb
